// *** logic/cbag_regs.vh ***
// Register indices, field positions and reset values of the circular
// buffer address generator. Assumes byte address = 4 * register index.
`ifndef CBAG_REGS_VH
`define CBAG_REGS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define CBAG_IDX_STATUS     10'h044
`define CBAG_IDX_CONTROL    10'h046
`define CBAG_IDX_X_START    10'h048
`define CBAG_IDX_X_END      10'h04a
`define CBAG_IDX_Y_START    10'h04c
`define CBAG_IDX_Y_END      10'h04e
`define CBAG_IDX_BITREV     10'h050

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CBAG_X_SEL_LSB      0
`define CBAG_X_SEL_MSB      3
`define CBAG_Y_SEL_LSB      4
`define CBAG_Y_SEL_MSB      7
`define CBAG_Y_EN_BIT       14
`define CBAG_X_EN_BIT       15
`define CBAG_SEL_OFF        4'hf

// ----------------------------------------------------------------
// Bit-reverse register fields
// ----------------------------------------------------------------
`define CBAG_BREV_EN_BIT    15
`define CBAG_BREV_MOD_MSB   14

// ----------------------------------------------------------------
// Request unit codes
// ----------------------------------------------------------------
`define CBAG_UNIT_X_READ    2'h0
`define CBAG_UNIT_X_WRITE   2'h1
`define CBAG_UNIT_Y         2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CBAG_RST_CONTROL    16'h00ff
`define CBAG_RST_BOUND      16'h0000
`define CBAG_RST_Y_END      16'h0001
`define CBAG_RST_BITREV     16'h0000

`endif

// *** logic/cbag_wrap_unit.v ***
// Next-pointer calculation for one circular buffer access.
// Assumes bounds are stable during the access; purely combinational.
`timescale 1ns/1ns

module cbag_wrap_unit (
	input  wire [15:0] ptr,
	input  wire [15:0] step,
	input  wire        decrement,
	input  wire [15:0] buf_start,
	input  wire [15:0] buf_end,
	input  wire        circ_on,
	input  wire        word_mode,
	output reg  [15:0] next_ptr,
	output reg         wrapped
);

	function is_pow2;
		input [16:0] len;
		begin
			is_pow2 = ((len & (len - 17'd1)) == 17'd0);
		end
	endfunction

	reg [16:0] len;
	reg [16:0] sum;
	reg        len_ok;
	reg        bidir;
	reg        above;
	reg        below;

	always @* begin
		// Length follows from the bounds; at most 64 Kbytes fits in 17 bits.
		len      = {1'b0, buf_end} - {1'b0, buf_start} + 17'd1;
		len_ok   = (buf_end >= buf_start);
		bidir    = len_ok && is_pow2(len);
		if (decrement) begin
			sum = {1'b0, ptr} - {1'b0, step};
		end else begin
			sum = {1'b0, ptr} + {1'b0, step};
		end
		above    = decrement ? (!sum[16] && sum[15:0] > buf_end) : (sum > {1'b0, buf_end});
		below    = decrement ? (sum[16] || sum[15:0] < buf_start) : (!sum[16] && sum[15:0] < buf_start);
		next_ptr = sum[15:0];
		wrapped  = 1'b0;
		// Unidirectional buffers check only the boundary they run towards.
		if (circ_on && len_ok && (!decrement || bidir) && above) begin
			next_ptr = buf_start;
			wrapped  = 1'b1;
		end else if (circ_on && len_ok && (decrement || bidir) && below) begin
			next_ptr = buf_end;
			wrapped  = 1'b1;
		end
		if (word_mode) begin
			next_ptr[0] = 1'b0;
		end
	end

endmodule

// *** logic/cbag_top.v ***
// Circular buffer address generator with its APB register file.
// Assumes requests come from core logic on core_clk; APB master on core_clk.
//
// Summary of operation
// - Power-of-two buffers run both ways, checking lower and upper bounds.
// - Y space circular addresses are word sized; address bit 0 is zero.
// - Length is end minus start plus one, at most 64 Kbytes.
// - X circular mode needs X select not 15 and X enable set.
// - Y circular mode needs Y select not 15 and Y enable set.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "cbag_regs.vh"

module cbag_top #(
	parameter ADDR_W = 12
) (
	input  wire              core_clk,
	input  wire              resetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	input  wire              req_valid,
	input  wire [1:0]        req_unit,
	input  wire [3:0]        req_wreg,
	input  wire [15:0]       req_ptr,
	input  wire [15:0]       req_step,
	input  wire              req_decrement,
	output reg               res_valid,
	output reg  [15:0]       res_ptr,
	output reg               res_wrapped,
	output reg               bit_reverse_enable,
	output reg  [14:0]       bit_reverse_modifier
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Only the two low byte lanes carry register bits; upper lanes are ignored.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wdata;
		input [3:0]  strb;
		begin
			merge16[7:0]  = strb[0] ? wdata[7:0] : old[7:0];
			merge16[15:8] = strb[1] ? wdata[15:8] : old[15:8];
		end
	endfunction

	function hit;
		input [ADDR_W-1:0] addr;
		input [9:0]        idx;
		begin
			hit = (addr[1:0] == 2'b00) && ({{(32-ADDR_W){1'b0}}, addr} == {20'h00000, idx, 2'b00});
		end
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [15:0] circular_control_reg;
	reg [15:0] x_buffer_start;
	reg [15:0] x_buffer_end;
	reg [15:0] y_buffer_start;
	reg [15:0] y_buffer_end;
	reg        last_wrap_x;
	reg        last_wrap_y;

	wire [3:0] x_pointer_select   = circular_control_reg[`CBAG_X_SEL_MSB:`CBAG_X_SEL_LSB];
	wire [3:0] y_pointer_select   = circular_control_reg[`CBAG_Y_SEL_MSB:`CBAG_Y_SEL_LSB];
	wire       x_circular_enable  = circular_control_reg[`CBAG_X_EN_BIT];
	wire       y_circular_enable  = circular_control_reg[`CBAG_Y_EN_BIT];
	// A select of 15 turns the space off in both its read and write units.
	wire       x_active           = x_circular_enable && (x_pointer_select != `CBAG_SEL_OFF);
	wire       y_active           = y_circular_enable && (y_pointer_select != `CBAG_SEL_OFF);
	wire       bus_setup          = psel && !penable;
	// A refused access never reaches a register, so a bad address cannot
	// disturb a neighbouring register.
	wire       bus_write          = psel && penable && pready && pwrite && !pslverr;

	// ----------------------------------------------------------------
	// APB read decode
	// ----------------------------------------------------------------
	reg [31:0] next_prdata;
	reg        next_err;

	always @* begin
		next_prdata = 32'h00000000;
		next_err    = 1'b0;
		if (hit(paddr, `CBAG_IDX_STATUS)) begin
			next_prdata = {28'h0000000, last_wrap_y, last_wrap_x, y_active, x_active};
		end else if (hit(paddr, `CBAG_IDX_CONTROL)) begin
			next_prdata = {16'h0000, circular_control_reg};
		end else if (hit(paddr, `CBAG_IDX_X_START)) begin
			next_prdata = {16'h0000, x_buffer_start};
		end else if (hit(paddr, `CBAG_IDX_X_END)) begin
			next_prdata = {16'h0000, x_buffer_end};
		end else if (hit(paddr, `CBAG_IDX_Y_START)) begin
			next_prdata = {16'h0000, y_buffer_start[15:1], 1'b0};
		end else if (hit(paddr, `CBAG_IDX_Y_END)) begin
			next_prdata = {16'h0000, y_buffer_end[15:1], 1'b1};
		end else if (hit(paddr, `CBAG_IDX_BITREV)) begin
			next_prdata = {16'h0000, bit_reverse_enable, bit_reverse_modifier};
		end else begin
			next_err = 1'b1;
		end
		// Writes answer with zero so that register contents never ride on a write.
		if (pwrite) begin
			next_prdata = 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// No wait state: answers are prepared at the setup edge so that
	// pready, prdata and pslverr all come straight from flip-flops.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready <= bus_setup;
			if (bus_setup) begin
				prdata  <= next_prdata;
				pslverr <= next_err;
			end else if (pready) begin
				prdata  <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// X bounds are plain storage, Y bounds keep start bit 0 clear and end bit 0 set; software must load them before enabling.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			circular_control_reg <= `CBAG_RST_CONTROL;
			x_buffer_start       <= `CBAG_RST_BOUND;
			x_buffer_end         <= `CBAG_RST_BOUND;
			y_buffer_start       <= `CBAG_RST_BOUND;
			y_buffer_end         <= `CBAG_RST_Y_END;
			bit_reverse_enable   <= 1'b0;
			bit_reverse_modifier <= 15'h0000;
		end else if (bus_write) begin
			if (hit(paddr, `CBAG_IDX_CONTROL)) begin
				circular_control_reg <= merge16(circular_control_reg, pwdata, pstrb) & `CBAG_RST_CONTROL |
					(merge16(circular_control_reg, pwdata, pstrb) & 16'hc000);
			end else if (hit(paddr, `CBAG_IDX_X_START)) begin
				x_buffer_start <= merge16(x_buffer_start, pwdata, pstrb);
			end else if (hit(paddr, `CBAG_IDX_X_END)) begin
				x_buffer_end <= merge16(x_buffer_end, pwdata, pstrb);
			end else if (hit(paddr, `CBAG_IDX_Y_START)) begin
				y_buffer_start <= merge16(y_buffer_start, pwdata, pstrb) & 16'hfffe;
			end else if (hit(paddr, `CBAG_IDX_Y_END)) begin
				y_buffer_end <= merge16(y_buffer_end, pwdata, pstrb) | 16'h0001;
			end else if (hit(paddr, `CBAG_IDX_BITREV)) begin
				{bit_reverse_enable, bit_reverse_modifier} <=
					merge16({bit_reverse_enable, bit_reverse_modifier}, pwdata, pstrb);
			end
		end
	end

	// ----------------------------------------------------------------
	// Address generation
	// ----------------------------------------------------------------
	// Pointer choice is left to software; the frame and stack pointers
	// are accepted even though using them would corrupt the stack.
	wire        is_y      = (req_unit == `CBAG_UNIT_Y);
	wire        is_x      = (req_unit == `CBAG_UNIT_X_READ) || (req_unit == `CBAG_UNIT_X_WRITE);
	wire        circ_x    = is_x && x_active && (req_wreg == x_pointer_select);
	wire        circ_y    = is_y && y_active && (req_wreg == y_pointer_select);
	wire [15:0] sel_start = is_y ? y_buffer_start : x_buffer_start;
	wire [15:0] sel_end   = is_y ? y_buffer_end : x_buffer_end;
	wire [15:0] calc_ptr;
	wire        calc_wrap;

	cbag_wrap_unit u_wrap (
		.ptr       (req_ptr),
		.step      (req_step),
		.decrement (req_decrement),
		.buf_start (sel_start),
		.buf_end   (sel_end),
		.circ_on   (circ_x || circ_y),
		.word_mode (circ_y),
		.next_ptr  (calc_ptr),
		.wrapped   (calc_wrap)
	);

	// The status flags follow the last request of each space; a plain
	// step with no space leaves both of them alone.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			res_valid   <= 1'b0;
			res_ptr     <= 16'h0000;
			res_wrapped <= 1'b0;
			last_wrap_x <= 1'b0;
			last_wrap_y <= 1'b0;
		end else begin
			res_valid <= req_valid;
			if (req_valid) begin
				res_ptr     <= calc_ptr;
				res_wrapped <= calc_wrap;
				if (is_y) begin
					last_wrap_y <= calc_wrap;
				end else if (is_x) begin
					last_wrap_x <= calc_wrap;
				end
			end
		end
	end

endmodule

// *** tb/cbag_top_sva.sv ***
// Port assertions for the circular buffer address generator.
// Assumes one core_clk domain and resetn active low.
`timescale 1ns/1ns
module cbag_top_sva #(
	parameter ADDR_W = 12
) (
	input logic              core_clk,
	input logic              resetn,
	input logic              psel,
	input logic              penable,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       prdata,
	input logic              pready,
	input logic              pslverr,
	input logic              req_valid,
	input logic [1:0]        req_unit,
	input logic [15:0]       req_ptr,
	input logic [15:0]       req_step,
	input logic              req_decrement,
	input logic              res_valid,
	input logic [15:0]       res_ptr,
	input logic              res_wrapped
);
	logic [15:0] plain_sum;

	always_comb plain_sum = req_decrement ? req_ptr - req_step : req_ptr + req_step;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_res_latency: assert property (req_valid |=> res_valid)
		else $error("result did not follow request");
	a_res_idle: assert property (!req_valid |=> !res_valid)
		else $error("result without request");
	a_plain_path: assert property (req_valid && req_unit == 2'h3 |=>
		res_ptr == $past(plain_sum) && !res_wrapped) else $error("plain step wrong");
	a_y_word: assert property (req_valid && req_unit == 2'h2 |=> !res_wrapped || !res_ptr[0])
		else $error("odd Y reload");
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_bad_align: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");

	c_wrap: cover property (res_wrapped);
	c_err: cover property (pslverr);
	c_y_req: cover property (req_valid && req_unit == 2'h2);
endmodule

// *** tb/cbag_core_model.sv ***
// Behavioural core issuing pointer updates to the address generator.
// Assumes requests start on core_clk rising edges after reset release.
`timescale 1ns/1ns
module cbag_core_model (
	input  logic        core_clk,
	output logic        req_valid,
	output logic [1:0]  req_unit,
	output logic [3:0]  req_wreg,
	output logic [15:0] req_ptr,
	output logic [15:0] req_step,
	output logic        req_decrement,
	input  logic        res_valid,
	input  logic [15:0] res_ptr,
	input  logic        res_wrapped
);
	initial begin
		{req_valid, req_unit, req_wreg, req_ptr, req_step, req_decrement} = '0;
	end

	// Callers never pick the frame or stack pointer and step each buffer legally.
	task issue(input logic [1:0] u, input logic [3:0] w, input logic [15:0] p, s, input logic d,
		output logic v, output logic [15:0] np, output logic wr);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_unit <= u;
		req_wreg <= w;
		req_ptr <= p;
		req_step <= s;
		req_decrement <= d;
		@(posedge core_clk);
		req_valid <= 1'b0;
		// Stale operands are scrambled so nothing can lean on them.
		req_ptr <= ~p;
		req_step <= ~s;
		// The result stands for one cycle; take it at the edge that ends it.
		@(posedge core_clk);
		v = res_valid;
		np = res_ptr;
		wr = res_wrapped;
	endtask
endmodule

// *** tb/cbag_top_tb_top.sv ***
// Self-checking bench: APB register traffic plus pointer requests.
// Assumes the core model drives the request port.
`timescale 1ns/1ns
module cbag_top_tb_top;
	logic        core_clk, resetn, psel, penable, pwrite, pslverr, pready, rerr;
	logic        req_valid, req_decrement, res_valid, res_wrapped, bit_reverse_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb, req_wreg;
	logic [1:0]  req_unit;
	logic [15:0] req_ptr, req_step, res_ptr;
	logic [14:0] bit_reverse_modifier;
	int          mismatches = 0;
	int          checks = 0;

	always #20 core_clk = ~core_clk;

	cbag_top #(.ADDR_W(12)) dut (
		.core_clk             (core_clk),
		.resetn               (resetn),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.pstrb                (pstrb),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.req_valid            (req_valid),
		.req_unit             (req_unit),
		.req_wreg             (req_wreg),
		.req_ptr              (req_ptr),
		.req_step             (req_step),
		.req_decrement        (req_decrement),
		.res_valid            (res_valid),
		.res_ptr              (res_ptr),
		.res_wrapped          (res_wrapped),
		.bit_reverse_enable   (bit_reverse_enable),
		.bit_reverse_modifier (bit_reverse_modifier)
	);
	cbag_core_model core (
		.core_clk      (core_clk),
		.req_valid     (req_valid),
		.req_unit      (req_unit),
		.req_wreg      (req_wreg),
		.req_ptr       (req_ptr),
		.req_step      (req_step),
		.req_decrement (req_decrement),
		.res_valid     (res_valid),
		.res_ptr       (res_ptr),
		.res_wrapped   (res_wrapped)
	);

	task close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// No local limit: a slave that never answers is ended by the watchdog.
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rq(input logic [1:0] u, input logic [3:0] w, input logic [15:0] p, s, input logic d,
		input logic [15:0] ep, input logic ew);
		logic v, wr;
		logic [15:0] np;
		core.issue(u, w, p, s, d, v, np, wr);
		check({31'h0, v}, 32'h1);
		check({16'h0, np}, {16'h0, ep});
		check({31'h0, wr}, {31'h0, ew});
	endtask

	initial begin
		core_clk = 0;
		resetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'h3;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		rw(0, 12'h118, 0); check(rdat, 32'h00ff);
		rw(0, 12'h138, 0); check(rdat, 32'h1);
		rw(1, 12'h118, 32'hffffffff); rw(0, 12'h118, 0); check(rdat, 32'hc0ff);
		rw(1, 12'h120, 32'h0000); rw(1, 12'h128, 32'hffff); rw(1, 12'h118, 32'h80f2);
		rq(0, 2, 16'hfffe, 2, 0, 16'h0000, 1);
		rw(1, 12'h120, 32'h0100); rw(1, 12'h128, 32'h010f);
		rq(0, 2, 16'h010e, 2, 0, 16'h0100, 1);
		rq(1, 2, 16'h0100, 2, 1, 16'h010f, 1);
		rq(0, 2, 16'h00f0, 2, 0, 16'h010f, 1);
		rq(0, 3, 16'h010e, 2, 0, 16'h0110, 0);
		rw(1, 12'h118, 32'h80ff); rq(1, 4'hf, 16'h010e, 2, 0, 16'h0110, 0);
		rw(1, 12'h118, 32'h00f2); rq(0, 2, 16'h010e, 2, 0, 16'h0110, 0);
		rw(1, 12'h130, 32'h0201); rw(0, 12'h130, 0); check(rdat, 32'h0200);
		rw(1, 12'h138, 32'h021e); rw(0, 12'h138, 0); check(rdat, 32'h021f);
		rw(1, 12'h118, 32'h402f);
		rq(2, 2, 16'h021e, 2, 0, 16'h0200, 1);
		rq(2, 2, 16'h0200, 2, 1, 16'h021e, 1);
		rq(3, 2, 16'hfffe, 4, 0, 16'h0002, 0);
		rw(0, 12'h110, 0); check({rerr, rdat[30:0]}, 32'ha);
		rw(1, 12'h118, 32'h002f); rq(2, 2, 16'h021e, 2, 0, 16'h0220, 0);
		rw(1, 12'h140, 32'h8005); rw(0, 12'h140, 0); check(rdat, 32'h8005);
		check({16'h0, bit_reverse_enable, bit_reverse_modifier}, 32'h8005);
		rw(0, 12'h1fc, 0); check({rerr, rdat[30:0]}, 32'h80000000);
		rw(1, 12'h119, 32'h1234); check({31'h0, rerr}, 32'h1);
		close_out;
	end

	initial begin
		#200000;
		mismatches++;
		close_out;
	end
endmodule

bind cbag_top cbag_top_sva #(.ADDR_W(ADDR_W)) sva (.core_clk(core_clk), .resetn(resetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.req_valid(req_valid), .req_unit(req_unit), .req_ptr(req_ptr), .req_step(req_step),
	.req_decrement(req_decrement), .res_valid(res_valid), .res_ptr(res_ptr), .res_wrapped(res_wrapped));
